//--- hw/bspi_pkg.sv
// Purpose: Shared constants for the burst SRAM pin interface.
// Assumes: The x18 build; sizes below are fixed at that build.
// Notes: Storage depth is a small stand-in for the real array.
package bspi_pkg;
    localparam int DATA_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int ADDR_W = 18;
    localparam int BURST = 4;
    localparam int BEAT_W = 2;
    localparam int STORE_AW = 4;
    localparam int STORE_WORDS = (1 << STORE_AW) * BURST;
    localparam int STORE_IW = STORE_AW + BEAT_W;
    // Bit positions inside the packed pin vector that is synchronised.
    localparam int PIN_D_LSB = 0;
    localparam int PIN_M_LSB = DATA_W;
    localparam int PIN_A_LSB = PIN_M_LSB + LANES;
    localparam int PIN_W_SEL = PIN_A_LSB + ADDR_W;
    localparam int PIN_R_SEL = PIN_W_SEL + 1;
    localparam int PIN_CLK_LSB = PIN_R_SEL + 1;
    localparam int PIN_W = PIN_CLK_LSB + 4;
    // Order of the four link clocks inside the clock group.
    localparam int CK_K = 0;
    localparam int CK_KN = 1;
    localparam int CK_C = 2;
    localparam int CK_CN = 3;
    localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
    localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
    localparam logic [PIN_W-1:0] PIN_RST = '1;
    localparam logic [DATA_W-1:0] DATA_RST = '0;
    localparam logic [ADDR_W-1:0] ADDR_RST = '0;
endpackage

//--- hw/bspi_store.sv
// Purpose: Flip-flop word store with per-lane write enables.
// Assumes: Words are indexed by burst address low bits and beat.
// Notes: Unwritten lanes keep their old contents.
`timescale 1ns/1ps
module bspi_store
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [bspi_pkg::STORE_IW-1:0] wr_idx,
    input wire logic [bspi_pkg::DATA_W-1:0] wr_data,
    input wire logic [bspi_pkg::LANES-1:0] wr_lane,
    input wire logic [bspi_pkg::STORE_IW-1:0] rd_idx,
    output logic [bspi_pkg::DATA_W-1:0] rd_data
);
    logic [bspi_pkg::DATA_W-1:0] mem_ff [bspi_pkg::STORE_WORDS];
    logic [bspi_pkg::DATA_W-1:0] nxt_mem [bspi_pkg::STORE_WORDS];
    logic [bspi_pkg::DATA_W-1:0] merged;

    genvar g;
    generate
        for (g = 0; g < bspi_pkg::LANES; g = g + 1)
        begin : g_lane
            // Lane g covers bits g*9+8 down to g*9.
            assign merged[g*bspi_pkg::LANE_W +: bspi_pkg::LANE_W] = wr_lane[g] ?
                wr_data[g*bspi_pkg::LANE_W +: bspi_pkg::LANE_W] :
                mem_ff[wr_idx][g*bspi_pkg::LANE_W +: bspi_pkg::LANE_W];
        end
    endgenerate

    always_comb
    begin
        nxt_mem = mem_ff;
        if (wr_en)
        begin
            nxt_mem[wr_idx] = merged;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < bspi_pkg::STORE_WORDS; i++)
            begin
                mem_ff[i] <= bspi_pkg::DATA_RST;
            end
        end
        else
        begin
            mem_ff <= nxt_mem;
        end
    end

    assign rd_data = mem_ff[rd_idx];
endmodule // bspi_store

//--- hw/bspi_top.sv
// Purpose: Pin-level burst SRAM device: write capture, read launch, output enable.
// Assumes: All pins, link clocks included, are sampled by ref_clk through two flops.
// Notes: Link clocks must be much slower than ref_clk so every edge is seen.
// Behaviour
// - Capture write data on both primary rises.
// - Lane masks active low, sampled both edges.
// - Each mask qualifies its own data word.
// - Deasserted mask leaves stored byte unchanged.
// - Mask 0 bits 8:0, mask 1 17:9.
// - Address latched on primary rise at start.
// - Deselected port ignores the address.
// - Read drives requested burst onto output.
// - Launch on output clock rises, else primary.
// - Output floats when no read pending.
// - Write words follow address on alternating rises.
// - Simultaneous read and write: read wins.
// - Adjacent same-direction request is ignored.
`timescale 1ns/1ps
module bspi_top
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic k,
    input wire logic k_n,
    input wire logic c,
    input wire logic c_n,
    input wire logic rd_sel_n,
    input wire logic wr_sel_n,
    input wire logic [bspi_pkg::ADDR_W-1:0] addr,
    input wire logic [bspi_pkg::LANES-1:0] lane_mask_n,
    input wire logic [bspi_pkg::DATA_W-1:0] d,
    output logic [bspi_pkg::DATA_W-1:0] q,
    output logic q_oe
);
    logic [bspi_pkg::PIN_W-1:0] pin_s1_ff;
    logic [bspi_pkg::PIN_W-1:0] pin_s2_ff;
    logic [3:0] ck_s3_ff;
    logic [3:0] ck_now;
    logic k_rise;
    logic kn_rise;
    logic single_clk;
    logic out_p_rise;
    logic out_n_rise;
    logic rd_sel;
    logic wr_sel;
    logic [bspi_pkg::ADDR_W-1:0] addr_s;
    logic [bspi_pkg::LANES-1:0] mask_s;
    logic [bspi_pkg::DATA_W-1:0] d_s;
    logic rd_go;
    logic wr_go;
    logic wr_cap;
    logic rd_launch;

    logic wr_act_ff, nxt_wr_act;
    logic [bspi_pkg::BEAT_W-1:0] wr_beat_ff, nxt_wr_beat;
    logic [bspi_pkg::ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
    logic wr_pend_ff, nxt_wr_pend;
    logic [bspi_pkg::ADDR_W-1:0] wr_pend_addr_ff, nxt_wr_pend_addr;
    logic wr_start_ff, nxt_wr_start;

    logic rd_act_ff, nxt_rd_act;
    logic [bspi_pkg::BEAT_W-1:0] rd_beat_ff, nxt_rd_beat;
    logic [bspi_pkg::ADDR_W-1:0] rd_addr_ff, nxt_rd_addr;
    logic rd_pend_ff, nxt_rd_pend;
    logic [bspi_pkg::ADDR_W-1:0] rd_pend_addr_ff, nxt_rd_pend_addr;
    logic rd_start_ff, nxt_rd_start;
    logic [bspi_pkg::DATA_W-1:0] q_ff, nxt_q;
    logic q_oe_ff, nxt_q_oe;
    logic [bspi_pkg::DATA_W-1:0] store_rd;

    // Every pin passes two flops; the clock group gets a third for edge finding.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1_ff <= bspi_pkg::PIN_RST;
            pin_s2_ff <= bspi_pkg::PIN_RST;
            ck_s3_ff <= 4'hF;
        end
        else
        begin
            // The clock group sits on top so it can be sliced off in one piece.
            pin_s1_ff <= {c_n, c, k_n, k,
                rd_sel_n, wr_sel_n,
                addr, lane_mask_n, d};
            pin_s2_ff <= pin_s1_ff;
            ck_s3_ff <= ck_now;
        end
    end

    assign ck_now = pin_s2_ff[bspi_pkg::PIN_CLK_LSB +: 4];
    assign k_rise = ck_now[bspi_pkg::CK_K] & ~ck_s3_ff[bspi_pkg::CK_K];
    assign kn_rise = ck_now[bspi_pkg::CK_KN] & ~ck_s3_ff[bspi_pkg::CK_KN];
    // Both output clocks held high means the primary pair times the outputs.
    assign single_clk = ck_now[bspi_pkg::CK_C] & ck_now[bspi_pkg::CK_CN] &
        ck_s3_ff[bspi_pkg::CK_C] & ck_s3_ff[bspi_pkg::CK_CN];
    assign out_p_rise = single_clk ? k_rise :
        (ck_now[bspi_pkg::CK_C] & ~ck_s3_ff[bspi_pkg::CK_C]);
    assign out_n_rise = single_clk ? kn_rise :
        (ck_now[bspi_pkg::CK_CN] & ~ck_s3_ff[bspi_pkg::CK_CN]);
    assign rd_sel = ~pin_s2_ff[bspi_pkg::PIN_R_SEL];
    assign wr_sel = ~pin_s2_ff[bspi_pkg::PIN_W_SEL];
    assign addr_s = pin_s2_ff[bspi_pkg::PIN_A_LSB +: bspi_pkg::ADDR_W];
    assign mask_s = pin_s2_ff[bspi_pkg::PIN_M_LSB +: bspi_pkg::LANES];
    assign d_s = pin_s2_ff[bspi_pkg::PIN_D_LSB +: bspi_pkg::DATA_W];

    // A start right after a start of the same kind is dropped; read beats write.
    assign rd_go = k_rise & rd_sel & ~rd_start_ff;
    assign wr_go = k_rise & wr_sel & ~rd_go & ~wr_start_ff;
    // Even beats arrive on the positive primary rise, odd beats on the negative.
    assign wr_cap = wr_act_ff & (wr_beat_ff[0] ? kn_rise : k_rise);
    assign rd_launch = rd_act_ff & (rd_beat_ff[0] ? out_p_rise : out_n_rise);

    always_comb
    begin
        nxt_wr_act = wr_act_ff;
        nxt_wr_beat = wr_beat_ff;
        nxt_wr_addr = wr_addr_ff;
        nxt_wr_pend = wr_pend_ff;
        nxt_wr_pend_addr = wr_pend_addr_ff;
        nxt_wr_start = k_rise ? wr_go : wr_start_ff;
        if (wr_cap)
        begin
            nxt_wr_beat = wr_beat_ff + bspi_pkg::BEAT_STEP;
            if (wr_beat_ff == bspi_pkg::BEAT_LAST)
            begin
                nxt_wr_act = wr_pend_ff;
                nxt_wr_addr = wr_pend_addr_ff;
                nxt_wr_pend = 1'b0;
            end
        end
        // A start during the tail of a burst waits until that burst ends.
        if (wr_go)
        begin
            if (nxt_wr_act)
            begin
                nxt_wr_pend = 1'b1;
                nxt_wr_pend_addr = addr_s;
            end
            else
            begin
                nxt_wr_act = 1'b1;
                nxt_wr_beat = bspi_pkg::BEAT_FIRST;
                nxt_wr_addr = addr_s;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_act_ff <= 1'b0;
            wr_beat_ff <= bspi_pkg::BEAT_FIRST;
            wr_addr_ff <= bspi_pkg::ADDR_RST;
            wr_pend_ff <= 1'b0;
            wr_pend_addr_ff <= bspi_pkg::ADDR_RST;
            wr_start_ff <= 1'b0;
        end
        else
        begin
            wr_act_ff <= nxt_wr_act;
            wr_beat_ff <= nxt_wr_beat;
            wr_addr_ff <= nxt_wr_addr;
            wr_pend_ff <= nxt_wr_pend;
            wr_pend_addr_ff <= nxt_wr_pend_addr;
            wr_start_ff <= nxt_wr_start;
        end
    end

    always_comb
    begin
        nxt_rd_act = rd_act_ff;
        nxt_rd_beat = rd_beat_ff;
        nxt_rd_addr = rd_addr_ff;
        nxt_rd_pend = rd_pend_ff;
        nxt_rd_pend_addr = rd_pend_addr_ff;
        nxt_rd_start = k_rise ? rd_go : rd_start_ff;
        nxt_q = q_ff;
        nxt_q_oe = q_oe_ff;
        if (rd_launch)
        begin
            nxt_q = store_rd;
            nxt_q_oe = 1'b1;
            nxt_rd_beat = rd_beat_ff + bspi_pkg::BEAT_STEP;
            if (rd_beat_ff == bspi_pkg::BEAT_LAST)
            begin
                nxt_rd_act = rd_pend_ff;
                nxt_rd_addr = rd_pend_addr_ff;
                nxt_rd_pend = 1'b0;
            end
        end
        else if (!rd_act_ff && (out_p_rise || out_n_rise))
        begin
            // The last word stands for one output half cycle, then the bus floats.
            nxt_q_oe = 1'b0;
        end
        if (rd_go)
        begin
            if (nxt_rd_act)
            begin
                nxt_rd_pend = 1'b1;
                nxt_rd_pend_addr = addr_s;
            end
            else
            begin
                nxt_rd_act = 1'b1;
                nxt_rd_beat = bspi_pkg::BEAT_FIRST;
                nxt_rd_addr = addr_s;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_act_ff <= 1'b0;
            rd_beat_ff <= bspi_pkg::BEAT_FIRST;
            rd_addr_ff <= bspi_pkg::ADDR_RST;
            rd_pend_ff <= 1'b0;
            rd_pend_addr_ff <= bspi_pkg::ADDR_RST;
            rd_start_ff <= 1'b0;
            q_ff <= bspi_pkg::DATA_RST;
            q_oe_ff <= 1'b0;
        end
        else
        begin
            rd_act_ff <= nxt_rd_act;
            rd_beat_ff <= nxt_rd_beat;
            rd_addr_ff <= nxt_rd_addr;
            rd_pend_ff <= nxt_rd_pend;
            rd_pend_addr_ff <= nxt_rd_pend_addr;
            rd_start_ff <= nxt_rd_start;
            q_ff <= nxt_q;
            q_oe_ff <= nxt_q_oe;
        end
    end

    bspi_store u_store
    (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .wr_en(wr_cap),
        .wr_idx({wr_addr_ff[bspi_pkg::STORE_AW-1:0], wr_beat_ff}),
        .wr_data(d_s),
        .wr_lane(~mask_s),
        .rd_idx({rd_addr_ff[bspi_pkg::STORE_AW-1:0], rd_beat_ff}),
        .rd_data(store_rd)
    );

    assign q = q_ff;
    assign q_oe = q_oe_ff;

    property p_wr_edge;
        @(posedge ref_clk) disable iff (!nrst)
        wr_cap |-> (k_rise || kn_rise);
    endproperty
    a_wr_edge: assert property (p_wr_edge) else $error("write word taken off a primary rise");

    property p_beat_parity;
        @(posedge ref_clk) disable iff (!nrst)
        wr_cap |-> (wr_beat_ff[0] == kn_rise) && (wr_beat_ff[0] != k_rise);
    endproperty
    a_beat_parity: assert property (p_beat_parity) else $error("write beat on wrong edge");

    property p_mask_store;
        @(posedge ref_clk) disable iff (!nrst)
        (wr_cap && mask_s[0] && !rd_launch && !rd_go && (wr_addr_ff[bspi_pkg::STORE_AW-1:0] ==
            rd_addr_ff[bspi_pkg::STORE_AW-1:0]) && (wr_beat_ff == rd_beat_ff))
        |=> (store_rd[bspi_pkg::LANE_W-1:0] == $past(store_rd[bspi_pkg::LANE_W-1:0]));
    endproperty
    a_mask_store: assert property (p_mask_store) else $error("masked lane changed");

    property p_addr_on_k;
        @(posedge ref_clk) disable iff (!nrst)
        !k_rise |=> $stable(rd_start_ff) && $stable(wr_start_ff);
    endproperty
    a_addr_on_k: assert property (p_addr_on_k) else $error("start taken off a K rise");

    property p_read_wins;
        @(posedge ref_clk) disable iff (!nrst)
        (k_rise && rd_sel && wr_sel && !rd_start_ff) |=> rd_start_ff && !wr_start_ff;
    endproperty
    a_read_wins: assert property (p_read_wins) else $error("write taken beside a read");

    property p_no_adjacent;
        @(posedge ref_clk) disable iff (!nrst)
        (k_rise && rd_start_ff) |=> !rd_start_ff;
    endproperty
    a_no_adjacent: assert property (p_no_adjacent) else $error("adjacent read accepted");

    property p_deselect;
        @(posedge ref_clk) disable iff (!nrst)
        (k_rise && !wr_sel) |=> !wr_start_ff;
    endproperty
    a_deselect: assert property (p_deselect) else $error("write started while deselected");

    property p_float;
        @(posedge ref_clk) disable iff (!nrst)
        (!rd_act_ff && (out_p_rise || out_n_rise)) |=> !q_oe_ff;
    endproperty
    a_float: assert property (p_float) else $error("output driven with no read");

    property p_launch_edge;
        @(posedge ref_clk) disable iff (!nrst)
        !(out_p_rise || out_n_rise) |=> $stable(q_ff) && $stable(q_oe_ff);
    endproperty
    a_launch_edge: assert property (p_launch_edge) else $error("output moved off a launch edge");

    property p_read_data;
        @(posedge ref_clk) disable iff (!nrst)
        rd_launch |=> q_oe_ff && (q_ff == $past(store_rd));
    endproperty
    a_read_data: assert property (p_read_data) else $error("read word not driven");
endmodule // bspi_top

//--- test/bspi_ctl_model.sv
// Purpose: Memory controller model that drives the burst SRAM pins.
// Assumes: One link period is 8 ref_clk cycles; pins change 1 ns after ref_clk.
// Notes: K runs free once started, since the device needs it at all times.
`timescale 1ns/1ps
module bspi_ctl_model
(
    input wire logic ref_clk,
    output logic k,
    output logic k_n,
    output logic c,
    output logic c_n,
    output logic rd_sel_n,
    output logic wr_sel_n,
    output logic [bspi_pkg::ADDR_W-1:0] addr,
    output logic [bspi_pkg::LANES-1:0] lane_mask_n,
    output logic [bspi_pkg::DATA_W-1:0] d,
    input wire logic [bspi_pkg::DATA_W-1:0] q,
    input wire logic q_oe
);
    logic run = 1'b0;
    logic dual = 1'b0;
    int ph = 0;
    initial
    begin
        {k, c} = 2'h0;
        {k_n, c_n} = 2'h3;
        {rd_sel_n, wr_sel_n} = 2'h3;
        addr = '0;
        lane_mask_n = '1;
        d = '0;
    end
    // The output pair lags K by one cycle so launch timing differs from single mode.
    always @(posedge ref_clk)
    begin
        if (run)
            ph <= ph + 1;
        #1;
        k = run && (ph % 8 < 4);
        k_n = !k;
        c = dual ? (ph % 8 > 0 && ph % 8 < 5) : 1'b1;
        c_n = dual ? !c : 1'b1;
    end
    task automatic to_phase(input int p);
        for (int n = 0; n < 9 && !(n > 0 && ph % 8 == p); n++)
        begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    // Starts one access at the next K rise; released buses carry inverted values.
    task automatic op(input logic rd, input logic wr, input logic dat,
        input logic [bspi_pkg::ADDR_W-1:0] a, input logic [bspi_pkg::DATA_W-1:0] w [4],
        input logic [bspi_pkg::LANES-1:0] m [4], output logic [bspi_pkg::DATA_W-1:0] got [4]);
        to_phase(6);
        rd_sel_n = !rd;
        wr_sel_n = !wr;
        addr = a;
        to_phase(2);
        {rd_sel_n, wr_sel_n} = 2'h3;
        addr = ~a;
        for (int i = 0; i < 5; i++)
        begin
            to_phase(i % 2 ? 2 : 6);
            if (rd && i > 0)
                // A floating bus is seen as the inverse so a missing enable shows up.
                got[i - 1] = q_oe ? q : ~q;
            if (dat)
            begin
                d = i < 4 ? w[i] : ~d;
                lane_mask_n = i < 4 ? m[i] : ~m[3];
            end
        end
    endtask
endmodule // bspi_ctl_model

//--- test/bspi_top_tb_top.sv
// Purpose: Self-checking bench for the burst SRAM pin interface.
// Assumes: Store starts at zero and is indexed by address bits 3:0.
// Notes: Reads sample q mid-way between launch edges with the output pair, one ref_clk cycle before the next launch with K alone.
`timescale 1ns/1ps
module bspi_top_tb_top;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic k, k_n, c, c_n, rd_sel_n, wr_sel_n, q_oe;
    logic [bspi_pkg::ADDR_W-1:0] addr;
    logic [bspi_pkg::LANES-1:0] lane_mask_n;
    logic [bspi_pkg::DATA_W-1:0] d, q;
    logic [bspi_pkg::DATA_W-1:0] mem [16][4];
    logic [31:0] seed = 32'hBD667381;
    logic [31:0] r;
    int num_errors = 0;
    int comparisons = 0;
    always #25 ref_clk = ~ref_clk;
    bspi_top dut (.ref_clk(ref_clk), .nrst(nrst), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
        .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr), .lane_mask_n(lane_mask_n),
        .d(d), .q(q), .q_oe(q_oe));
    bspi_ctl_model ctl (.ref_clk(ref_clk), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
        .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr), .lane_mask_n(lane_mask_n),
        .d(d), .q(q), .q_oe(q_oe));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [bspi_pkg::DATA_W-1:0] merge(input logic [17:0] old,
        input logic [17:0] nw, input logic [bspi_pkg::LANES-1:0] mk);
        logic [bspi_pkg::DATA_W-1:0] res;
        res = old;
        for (int l = 0; l < bspi_pkg::LANES; l++)
            if (!mk[l])
                res[l * bspi_pkg::LANE_W +: bspi_pkg::LANE_W] = nw[l * 9 +: 9];
        return res;
    endfunction
    task automatic check(input logic [bspi_pkg::DATA_W-1:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Write data is only recorded when it is really sent and no read contends.
    task automatic run_op(input logic rd, input logic wr, input logic dat,
        input logic [bspi_pkg::ADDR_W-1:0] a);
        logic [bspi_pkg::DATA_W-1:0] ww [4];
        logic [bspi_pkg::DATA_W-1:0] gg [4];
        logic [bspi_pkg::LANES-1:0] mm [4];
        logic [31:0] t;
        for (int i = 0; i < 4; i++)
        begin
            t = rnd();
            ww[i] = t[17:0];
            mm[i] = t[31:30];
        end
        ctl.op(rd, wr, dat, a, ww, mm, gg);
        for (int i = 0; i < 4 && rd; i++)
            check(gg[i], mem[a[3:0]][i]);
        if (rd)
        begin
            ctl.to_phase(2);
            check({17'h0, q_oe}, 18'h0);
        end
        for (int i = 0; i < 4 && wr && !rd && dat; i++)
            mem[a[3:0]][i] = merge(mem[a[3:0]][i], ww[i], mm[i]);
    endtask
    initial
    begin
        #400000;
        num_errors++;
        $display("[FAIL] %0t ns: run did not finish", $time);
        print_verdict();
    end
    initial
    begin
        foreach (mem[i, j])
            mem[i][j] = '0;
        repeat (4) @(posedge ref_clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        check({17'h0, q_oe}, 18'h0);
        ctl.run = 1'b1;
        for (int t = 0; t < 32; t++)
        begin
            r = rnd();
            run_op(t >= 16, t < 16, 1'b1, {r[17:4], 4'(t)});
        end
        $display("test write and read back done");
        r = rnd();
        run_op(1'b1, 1'b1, 1'b1, r[17:0]);
        run_op(1'b1, 1'b0, 1'b0, r[17:0]);
        $display("test read beats write done");
        fork
            run_op(1'b0, 1'b1, 1'b1, 18'h00005);
            #400 run_op(1'b0, 1'b1, 1'b0, 18'h00006);
        join
        run_op(1'b1, 1'b0, 1'b0, 18'h00005);
        run_op(1'b1, 1'b0, 1'b0, 18'h00006);
        $display("test adjacent writes done");
        fork
            run_op(1'b1, 1'b0, 1'b0, 18'h00009);
            #400 run_op(1'b0, 1'b1, 1'b1, 18'h0000A);
        join
        run_op(1'b1, 1'b0, 1'b0, 18'h0000A);
        $display("test alternating access done");
        ctl.dual = 1'b1;
        for (int t = 0; t < 16; t++)
            run_op(1'b1, 1'b0, 1'b0, 18'(t));
        $display("test output clock pair done");
        print_verdict();
    end
endmodule // bspi_top_tb_top
